// ===== bench/tb_top.sv
// Self-checking bench for the periodic timer, driven over its Avalon-MM registers
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ptm_pkg::*;

   // ----------------------------------------------------------------
   // Signals, addresses and scenario tables
   // ----------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        ext_clk_pin;
   logic        timer_out;
   logic        timer_out_en;
   logic        duty_match_flag;
   logic        period_match_flag;
   logic [7:0]  rd;
   logic [7:0]  v;
   int          hi;
   int          bad_count;
   int          num_checks;
   localparam logic [5:0] A_C0 = {1'b0, PTM_OFS_CTRL0};
   localparam logic [5:0] A_C1 = {1'b0, PTM_OFS_CTRL1};
   localparam logic [5:0] A_CL = {1'b0, PTM_OFS_CNT_LO};
   localparam logic [5:0] A_CH = {1'b0, PTM_OFS_CNT_HI};
   localparam logic [5:0] A_PL = {1'b0, PTM_OFS_PER_LO};
   localparam logic [5:0] A_PH = {1'b0, PTM_OFS_PER_HI};
   localparam logic [7:0] OFF  = {1'b0, PTM_CK_SYS, 4'h0};
   // Compare-mode pin action table: pin function, initial level, level after match
   localparam logic [1:0] TIO [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
   localparam logic       TOC [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   localparam logic       TEX [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   // PWM table: pin fn, out ctrl, invert, clear sel, duty, period, cycles, high cycles
   localparam int PW [7][8] = '{'{2, 1, 0, 1, 2, 8, 80, 20}, '{2, 1, 0, 0, 9, 8, 80, 80},
                                '{2, 1, 1, 0, 2, 8, 80, 60}, '{2, 0, 0, 0, 2, 8, 80, 60},
                                '{0, 1, 0, 0, 2, 8, 80, 0},  '{1, 1, 0, 0, 2, 8, 80, 80},
                                '{2, 1, 0, 0, 512, 0, 2048, 1024}};

   // Device under test
   ptm_timer ptm_timer_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_clk_pin(ext_clk_pin), .timer_out(timer_out), .timer_out_en(timer_out_en),
      .duty_match_flag(duty_match_flag), .period_match_flag(period_match_flag));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] c1(logic [1:0] md, logic [1:0] io, logic oc, logic pol, logic cl);
      return {md, io, oc, pol, 1'b0, cl};
   endfunction

   function automatic logic [7:0] c0(logic [2:0] ck);
      return {1'b0, ck, 1'b1, 3'h0};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      chk(n < 50, 1'b1);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Idle edge so a following call never re-drives the strobes in this time step
      @(posedge clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hF);
      chk(rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic cnt_hi(input int n);
      hi = 0;
      repeat (n) begin
         @(posedge clk);
         if (timer_out === 1'b1) hi++;
      end
   endtask

   // Stop, program control, duty and period, clear flags, then start
   task automatic cfg(input logic [7:0] ctl1, input logic [9:0] duty, input logic [9:0] per,
                      input logic [7:0] ctl0);
      wr(A_C0, 8'h00);
      wr(A_C1, ctl1);
      wr({1'b0, PTM_OFS_DUTY_LO}, duty[7:0]);
      wr({1'b0, PTM_OFS_DUTY_HI}, {6'h0, duty[9:8]});
      wr(A_PL, per[7:0]);
      wr(A_PH, {6'h0, per[9:8]});
      wr(PTM_OFS_FLAGS, 8'h03);
      wr(A_C0, ctl0);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      ext_clk_pin = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a <= 36; a += 4) rchk(6'(a), 8'h00);
      wr(A_PL, 8'hA5);
      wr(A_PH, 8'hFF);
      rchk(A_PL, 8'hA5);
      rchk(A_PH, 8'h03);
      bus(1'b1, A_PL, 8'h3C, 4'hE);
      rchk(A_PL, 8'hA5);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         cfg(c1(PTM_MD_CMP, TIO[i], TOC[i], 1'b0, 1'b0), 10'd20, 10'd0, c0(PTM_CK_SYS));
         cyc(3);
         chk(timer_out, TOC[i]);
         chk(timer_out_en, 1'b1);
         hi = 0;
         while (duty_match_flag !== 1'b1 && hi < 60) begin
            @(posedge clk);
            hi++;
         end
         cyc(2);
         chk(timer_out, TEX[i]);
         chk(period_match_flag, 1'b0);
      end
      $display("test pin actions done");
      for (int m = 0; m < 2; m++) begin
         cfg(c1(m ? PTM_MD_TMR : PTM_MD_CMP, PTM_IO_NONE, 1'b0, 1'b0, 1'b0), 10'd4, 10'd10, c0(PTM_CK_SYS));
         cyc(40);
         chk({duty_match_flag, period_match_flag}, 2'b11);
         chk(timer_out_en, m == 0);
         bus(1'b0, A_CL, 8'h00, 4'hF);
         chk(rd < 10, 1'b1);
      end
      cfg(c1(PTM_MD_CMP, PTM_IO_NONE, 1'b0, 1'b0, 1'b1), 10'd6, 10'd2, c0(PTM_CK_SYS));
      cyc(40);
      chk({duty_match_flag, period_match_flag}, 2'b10);
      bus(1'b0, A_CL, 8'h00, 4'hF);
      chk(rd < 6, 1'b1);
      cfg(c1(PTM_MD_CMP, PTM_IO_NONE, 1'b0, 1'b0, 1'b1), 10'd0, 10'd5, c0(PTM_CK_SYS));
      cyc(600);
      rchk(A_CH, 8'h02);
      cyc(500);
      chk({duty_match_flag, period_match_flag}, 2'b00);
      $display("test clearing done");
      for (int k = 0; k < 2; k++) begin
         cfg(c1(PTM_MD_TMR, 2'h0, 1'b0, 1'b0, 1'b0), 10'd0, 10'd0, c0(k ? PTM_CK_DIV4 : PTM_CK_SYS));
         bus(1'b0, A_CL, 8'h00, 4'hF);
         v = rd;
         repeat (k ? 4 : 1) bus(1'b0, A_CL, 8'h00, 4'hF);
         chk(rd, v + 8'h03);
      end
      wr(A_C0, OFF);
      bus(1'b0, A_CL, 8'h00, 4'hF);
      v = rd;
      cyc(10);
      rchk(A_CL, v);
      for (int k = 0; k < 2; k++) begin
         cfg(c1(PTM_MD_TMR, 2'h0, 1'b0, 1'b0, 1'b0), 10'd0, 10'd0, c0(k ? PTM_CK_PIN_F : PTM_CK_PIN_R));
         repeat (5) begin
            ext_clk_pin <= 1'b1;
            cyc(4);
            ext_clk_pin <= 1'b0;
            cyc(4);
         end
         cyc(4);
         rchk(A_CL, 8'h05);
      end
      $display("test counting done");
      for (int i = 0; i < 7; i++) begin
         cfg(c1(PTM_MD_PWM, 2'(PW[i][0]), 1'(PW[i][1]), 1'(PW[i][2]), 1'(PW[i][3])), 10'(PW[i][4]),
             10'(PW[i][5]), c0(PTM_CK_SYS));
         cyc(4);
         cnt_hi(PW[i][6]);
         chk(hi, PW[i][7]);
         chk({duty_match_flag, period_match_flag}, {PW[i][4] < PW[i][5] || PW[i][5] == 0, 1'b1});
      end
      $display("test pwm done");
      cfg(c1(PTM_MD_PWM, PTM_IO_TOGGLE, 1'b1, 1'b0, 1'b1), 10'd5, 10'd3, c0(PTM_CK_SYS));
      cnt_hi(20);
      chk(hi, 6);
      chk(duty_match_flag, 1'b1);
      rchk(A_C0, OFF);
      wr(PTM_OFS_FLAGS, 8'h03);
      ext_clk_pin <= 1'b1;
      cnt_hi(24);
      chk(hi, 6);
      chk(duty_match_flag, 1'b1);
      ext_clk_pin <= 1'b0;
      cfg(c1(PTM_MD_PWM, PTM_IO_TOGGLE, 1'b1, 1'b0, 1'b0), 10'd100, 10'd3, c0(PTM_CK_SYS));
      cyc(10);
      chk(timer_out, 1'b1);
      wr(A_C0, OFF);
      cyc(3);
      chk(timer_out, 1'b0);
      $display("test single pulse done");
      final_report;
   end

   // Watchdog against a hung bus or wait
   initial begin
      #200000;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      final_report;
   end
endmodule // tb_top

// ===== src/ptm_pkg.sv
// Package with register map, field layout, reset values and modes of the periodic timer
package ptm_pkg;

   // ----------------------------------------------------------------
   // Register word offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [4:0] PTM_OFS_CTRL0   = 5'h00;
   localparam logic [4:0] PTM_OFS_CTRL1   = 5'h04;
   localparam logic [4:0] PTM_OFS_CNT_LO  = 5'h08;
   localparam logic [4:0] PTM_OFS_CNT_HI  = 5'h0C;
   localparam logic [4:0] PTM_OFS_DUTY_LO = 5'h10;
   localparam logic [4:0] PTM_OFS_DUTY_HI = 5'h14;
   localparam logic [4:0] PTM_OFS_PER_LO  = 5'h18;
   localparam logic [4:0] PTM_OFS_PER_HI  = 5'h1C;
   localparam logic [5:0] PTM_OFS_FLAGS   = 6'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PTM_CTRL0_ON_BIT  = 3;
   localparam int PTM_CTRL0_CKS_LSB = 4;
   localparam int PTM_CTRL1_CCLR    = 0;
   localparam int PTM_CTRL1_POL     = 2;
   localparam int PTM_CTRL1_OC      = 3;
   localparam int PTM_CTRL1_IO_LSB  = 4;
   localparam int PTM_CTRL1_MD_LSB  = 6;
   localparam int PTM_FLAG_DUTY     = 0;
   localparam int PTM_FLAG_PER      = 1;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] PTM_RST_BYTE   = 8'h00;
   localparam logic [9:0] PTM_CNT_MAX    = 10'h3FF;
   localparam logic [1:0] PTM_MD_CMP     = 2'h0;
   localparam logic [1:0] PTM_MD_PWM     = 2'h2;
   localparam logic [1:0] PTM_MD_TMR     = 2'h3;
   localparam logic [1:0] PTM_IO_NONE    = 2'h0;
   localparam logic [1:0] PTM_IO_LOW     = 2'h1;
   localparam logic [1:0] PTM_IO_HIGH    = 2'h2;
   localparam logic [1:0] PTM_IO_TOGGLE  = 2'h3;
   localparam logic [2:0] PTM_CK_DIV4    = 3'h0;
   localparam logic [2:0] PTM_CK_SYS     = 3'h1;
   localparam logic [2:0] PTM_CK_PIN_R   = 3'h6;
   localparam logic [2:0] PTM_CK_PIN_F   = 3'h7;
   localparam logic [1:0] PTM_DIV4_LAST  = 2'h3;

   typedef enum logic [0:0] {PTM_BUS_IDLE, PTM_BUS_ACK} ptm_bus_e;

endpackage : ptm_pkg

// ===== src/ptm_timer.sv
// Periodic timer with period and duty comparators, four modes and an Avalon-MM slave
import ptm_pkg::*;

module ptm_timer (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        ext_clk_pin,
   output logic             timer_out,
   output logic             timer_out_en,
   output logic             duty_match_flag,
   output logic             period_match_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ptm_bus_e   bus_reg;
   logic [7:0] ctrl0_reg;
   logic [7:0] ctrl1_reg;
   logic [9:0] duty_reg;
   logic [9:0] per_reg;
   logic [9:0] cnt_reg;
   logic [1:0] div_reg;
   logic       pin_s1_reg;
   logic       pin_s2_reg;
   logic       pin_d_reg;
   logic       on_d_reg;
   logic       lvl_reg;
   logic       dflag_reg;
   logic       pflag_reg;
   logic       wr_go;
   logic       rd_go;
   logic [1:0] mode;
   logic [1:0] pfun;
   logic [2:0] cks;
   logic       on_bit;
   logic       on_rise;
   logic       tick;
   logic       pin_edge;
   logic       single;
   logic       pwm;
   logic       duty_hit;
   logic       per_hit;
   logic       ovf;
   logic       clr_cnt;
   logic       pwm_active;
   logic [9:0] cnt_next;
   logic [7:0] rd_byte;

   assign mode   = ctrl1_reg[PTM_CTRL1_MD_LSB +: 2];
   assign pfun   = ctrl1_reg[PTM_CTRL1_IO_LSB +: 2];
   assign cks    = ctrl0_reg[PTM_CTRL0_CKS_LSB +: 3];
   assign on_bit = ctrl0_reg[PTM_CTRL0_ON_BIT];
   assign pwm    = (mode == PTM_MD_PWM) && (pfun != PTM_IO_TOGGLE);
   assign single = (mode == PTM_MD_PWM) && (pfun == PTM_IO_TOGGLE);
   assign on_rise = on_bit && !on_d_reg;

   // ----------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then the access completes
   // ----------------------------------------------------------------
   assign avs_waitrequest = (avs_read || avs_write) && (bus_reg == PTM_BUS_IDLE);
   assign wr_go = avs_write && (bus_reg == PTM_BUS_ACK) && avs_byteenable[0];
   assign rd_go = avs_read && (bus_reg == PTM_BUS_ACK);

   // Handshake state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_reg <= PTM_BUS_IDLE;
      end else if (clk_en) begin
         if (bus_reg == PTM_BUS_ACK) begin
            bus_reg <= PTM_BUS_IDLE;
         end else if (avs_read || avs_write) begin
            bus_reg <= PTM_BUS_ACK;
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_byte = 8'h00;
      case (avs_address)
         {1'b0, PTM_OFS_CTRL0}:   rd_byte = {ctrl0_reg[7:3], 3'b000};
         {1'b0, PTM_OFS_CTRL1}:   rd_byte = ctrl1_reg;
         {1'b0, PTM_OFS_CNT_LO}:  rd_byte = cnt_reg[7:0];
         {1'b0, PTM_OFS_CNT_HI}:  rd_byte = {6'b0, cnt_reg[9:8]};
         {1'b0, PTM_OFS_DUTY_LO}: rd_byte = duty_reg[7:0];
         {1'b0, PTM_OFS_DUTY_HI}: rd_byte = {6'b0, duty_reg[9:8]};
         {1'b0, PTM_OFS_PER_LO}:  rd_byte = per_reg[7:0];
         {1'b0, PTM_OFS_PER_HI}:  rd_byte = {6'b0, per_reg[9:8]};
         PTM_OFS_FLAGS:           rd_byte = {6'b0, pflag_reg, dflag_reg};
         default:                 rd_byte = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (clk_en && avs_read && bus_reg == PTM_BUS_IDLE) begin
         avs_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // Configuration and compare registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl1_reg <= PTM_RST_BYTE;
         duty_reg  <= {2'b0, PTM_RST_BYTE};
         per_reg   <= {2'b0, PTM_RST_BYTE};
      end else if (clk_en && wr_go) begin
         case (avs_address)
            {1'b0, PTM_OFS_CTRL1}:   ctrl1_reg <= avs_writedata[7:0] & 8'hFD;
            {1'b0, PTM_OFS_DUTY_LO}: duty_reg[7:0] <= avs_writedata[7:0];
            {1'b0, PTM_OFS_DUTY_HI}: duty_reg[9:8] <= avs_writedata[1:0];
            {1'b0, PTM_OFS_PER_LO}:  per_reg[7:0] <= avs_writedata[7:0];
            {1'b0, PTM_OFS_PER_HI}:  per_reg[9:8] <= avs_writedata[1:0];
            default:                 ctrl1_reg <= ctrl1_reg;
         endcase
      end
   end

   // Control 0: clock select and enable; hardware sets/clears enable in single pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl0_reg <= PTM_RST_BYTE;
      end else if (clk_en) begin
         if (wr_go && avs_address == {1'b0, PTM_OFS_CTRL0}) begin
            ctrl0_reg <= {avs_writedata[7:3], 3'b000};
         end else if (single && on_bit && duty_hit) begin
            ctrl0_reg[PTM_CTRL0_ON_BIT] <= 1'b0;
         end else if (single && !on_bit && pin_edge) begin
            ctrl0_reg[PTM_CTRL0_ON_BIT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock source: pin synchroniser, edge detect, divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_d_reg  <= 1'b0;
         div_reg    <= 2'b00;
         on_d_reg   <= 1'b0;
      end else if (clk_en) begin
         pin_s1_reg <= ext_clk_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg  <= pin_s2_reg;
         div_reg    <= div_reg + 2'b01;
         on_d_reg   <= on_bit;
      end
   end

   // Active pin edge follows the clock select edge choice
   assign pin_edge = (cks == PTM_CK_PIN_F) ? (pin_d_reg && !pin_s2_reg) : (!pin_d_reg && pin_s2_reg);

   // Count tick per selected source; other codes fall back to system clock
   always_comb begin
      case (cks)
         PTM_CK_DIV4:  tick = (div_reg == PTM_DIV4_LAST);
         PTM_CK_SYS:   tick = 1'b1;
         PTM_CK_PIN_R: tick = pin_edge;
         PTM_CK_PIN_F: tick = pin_edge;
         default:      tick = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // Comparators and counter
   // ----------------------------------------------------------------
   assign cnt_next = cnt_reg + 10'd1;
   assign ovf      = on_bit && tick && (cnt_reg == PTM_CNT_MAX);
   // Duty match on the tick that reaches the compare value; zero never matches
   assign duty_hit = on_bit && tick && !on_rise && (duty_reg != 10'd0) && (cnt_next == duty_reg);
   // Period match; zero means the overflow at 3FF
   assign per_hit  = on_bit && tick && !on_rise && ((per_reg == 10'd0) ? ovf : (cnt_next == per_reg));

   // Which match clears the counter in each mode
   always_comb begin
      if (single) begin
         clr_cnt = 1'b0;
      end else if (pwm) begin
         clr_cnt = per_hit;
      end else if (ctrl1_reg[PTM_CTRL1_CCLR]) begin
         clr_cnt = duty_hit || ovf;
      end else begin
         clr_cnt = per_hit;
      end
   end

   // Counter: zeroed on enable rise, held while off
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= 10'd0;
      end else if (clk_en) begin
         if (on_rise) begin
            cnt_reg <= 10'd0;
         end else if (on_bit && tick) begin
            cnt_reg <= clr_cnt ? 10'd0 : cnt_next;
         end
      end
   end

   // Sticky flags; an event beats a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dflag_reg <= 1'b0;
         pflag_reg <= 1'b0;
      end else if (clk_en) begin
         if (duty_hit) begin
            dflag_reg <= 1'b1;
         end else if (wr_go && avs_address == PTM_OFS_FLAGS && avs_writedata[PTM_FLAG_DUTY]) begin
            dflag_reg <= 1'b0;
         end
         if (per_hit && !single && (pwm || !ctrl1_reg[PTM_CTRL1_CCLR])) begin
            pflag_reg <= 1'b1;
         end else if (wr_go && avs_address == PTM_OFS_FLAGS && avs_writedata[PTM_FLAG_PER]) begin
            pflag_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output pin
   // ----------------------------------------------------------------
   // PWM active while counter below duty; duty at or above period stays active
   assign pwm_active = (per_reg == 10'd0) ? (cnt_reg < duty_reg) || (duty_reg == PTM_CNT_MAX)
                                          : (duty_reg >= per_reg) || (cnt_reg < duty_reg);

   // Compare-mode level and single-pulse state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lvl_reg <= 1'b0;
      end else if (clk_en) begin
         if (on_rise) begin
            lvl_reg <= single ? ctrl1_reg[PTM_CTRL1_OC] : ctrl1_reg[PTM_CTRL1_OC];
         end else if (mode == PTM_MD_CMP && duty_hit) begin
            case (pfun)
               PTM_IO_LOW:    lvl_reg <= 1'b0;
               PTM_IO_HIGH:   lvl_reg <= 1'b1;
               PTM_IO_TOGGLE: lvl_reg <= !lvl_reg;
               default:       lvl_reg <= lvl_reg;
            endcase
         end
      end
   end

   // Final pin: compare level, PWM or pulse, with polarity and invert
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_out    <= 1'b0;
         timer_out_en <= 1'b0;
      end else if (clk_en) begin
         timer_out_en <= (mode != PTM_MD_TMR) && (mode != 2'b01);
         if (mode == PTM_MD_PWM) begin
            case (pfun)
               PTM_IO_NONE:   timer_out <= !ctrl1_reg[PTM_CTRL1_OC] ^ ctrl1_reg[PTM_CTRL1_POL];
               PTM_IO_LOW:    timer_out <= ctrl1_reg[PTM_CTRL1_OC] ^ ctrl1_reg[PTM_CTRL1_POL];
               PTM_IO_HIGH:   timer_out <= (pwm_active ~^ ctrl1_reg[PTM_CTRL1_OC]) ^ ctrl1_reg[PTM_CTRL1_POL];
               default:       timer_out <= (on_bit ~^ ctrl1_reg[PTM_CTRL1_OC]) ^ ctrl1_reg[PTM_CTRL1_POL];
            endcase
         end else if (mode == PTM_MD_CMP) begin
            timer_out <= lvl_reg ^ ctrl1_reg[PTM_CTRL1_POL];
         end else begin
            timer_out <= 1'b0;
         end
      end
   end

   assign duty_match_flag   = dflag_reg;
   assign period_match_flag = pflag_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   per_flag_cclr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode == PTM_MD_CMP && ctrl1_reg[PTM_CTRL1_CCLR] && !pflag_reg) |=> !pflag_reg)
      else $error("period flag set with duty clear source");
   cnt_zero_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && on_rise) |=> (cnt_reg == 10'd0))
      else $error("counter not zeroed on enable rise");
   cnt_hold_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && !on_bit && !on_d_reg) |=> $stable(cnt_reg))
      else $error("counter moved while disabled");
   per_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode == PTM_MD_CMP && !ctrl1_reg[PTM_CTRL1_CCLR] && per_hit) |=> (cnt_reg == 10'd0) && pflag_reg)
      else $error("period match did not clear and flag");
   duty_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (duty_reg == 10'd0) |-> !duty_hit)
      else $error("duty match with zero duty value");
   pulse_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && single && on_bit && duty_hit && !wr_go) |=> !on_bit && dflag_reg)
      else $error("pulse did not end on duty match");
   pulse_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && single && !on_bit && pin_edge && !wr_go) |=> on_bit)
      else $error("pin edge did not start pulse");
   init_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && on_rise && mode == PTM_MD_CMP) |=> (lvl_reg == $past(ctrl1_reg[PTM_CTRL1_OC])))
      else $error("initial level not loaded");
   tmr_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode == PTM_MD_TMR) |=> !timer_out_en)
      else $error("pin driven in timer mode");
   flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dflag_reg && !wr_go) |=> dflag_reg)
      else $error("duty flag dropped without clear");
   // Read data carries one byte, upper lanes always zero
   rd_upper_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      avs_readdata[31:8] == 24'h00_0000)
      else $error("read data upper lanes not zero");
   // Every access waits exactly one cycle
   bus_wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && (avs_read || avs_write) && bus_reg == PTM_BUS_IDLE) |-> avs_waitrequest)
      else $error("first access cycle not held off");
   bus_done_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && (avs_read || avs_write) && bus_reg == PTM_BUS_IDLE) |=> !avs_waitrequest)
      else $error("access not completed after one wait");
   // Counter steps by one on each plain tick
   cnt_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && on_bit && tick && !on_rise && !clr_cnt) |=> cnt_reg == $past(cnt_reg) + 10'd1)
      else $error("counter did not step by one");
   // Period match alone never moves the compare level
   per_pin_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && mode == PTM_MD_CMP && per_hit && !duty_hit && !on_rise) |=> $stable(lvl_reg))
      else $error("period match moved pin level");
   // Duty at or above period keeps the PWM pin active
   pwm_full_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && pwm && pfun == PTM_IO_HIGH && per_reg != 10'd0 && duty_reg >= per_reg)
      |=> timer_out == ($past(ctrl1_reg[PTM_CTRL1_OC]) ^ $past(ctrl1_reg[PTM_CTRL1_POL])))
      else $error("full duty PWM not active");
   // Forced inactive level while PWM counting runs on
   pwm_force_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && pwm && pfun == PTM_IO_NONE)
      |=> timer_out == (!$past(ctrl1_reg[PTM_CTRL1_OC]) ^ $past(ctrl1_reg[PTM_CTRL1_POL])))
      else $error("forced inactive level wrong");

   pwm_run_c:    cover property (@(posedge clk) disable iff (!rst_n) pwm && per_hit);
   pulse_run_c:  cover property (@(posedge clk) disable iff (!rst_n) single && duty_hit);
   cmp_toggle_c: cover property (@(posedge clk) disable iff (!rst_n) mode == PTM_MD_CMP && duty_hit && pfun == PTM_IO_TOGGLE);
   pin_trig_c:   cover property (@(posedge clk) disable iff (!rst_n) single && !on_bit && pin_edge);
   duty_clr_c:   cover property (@(posedge clk) disable iff (!rst_n) mode == PTM_MD_CMP && ctrl1_reg[PTM_CTRL1_CCLR] && duty_hit);

endmodule // ptm_timer
